/* column_sample_hold_sequencer.sv */
`timescale 1ns/1ps
// What this block does
// - bank switches reset, then move on inhibit edges
// - controller keeps clocks running during inhibit
// - column outputs float while inhibit is high
// - inhibit fall swaps sampling and holding banks
// - controller flips common voltage during inhibit
// - controller resets once per vertical blanking
// - long start pulse does not move sampling
// - stripe mode samples three inputs, phase a
// - stripe mode: controller holds phases b, c low
// - delta/mosaic: three phases, inputs sampled serially
// - controller holds inhibit five shift clocks
// - controller sends inhibit pulse after reset
// - works at 15/8 MHz shift clocks
// - cascade timing same in both sampling modes
// - array select pins decode four modes
// - direction pin sets column walk order
// - start captured on phase a rising edge
// - no sampling until first inhibit pulse
module column_sample_hold_sequencer (
  input  wire logic         hclk,                  // system clock
  input  wire logic         hresetn,               // async reset, active low
  output logic [239:0]      column_sampling_pulse, // one-hot sampling group
  output logic [1:0]        video_select,          // 0 all inputs, else input 1..3
  output logic              column_output_enable,  // outputs tied to hold bank
  output logic              hold_bank_switch_a1,   // bank a on sampling side
  output logic              hold_bank_switch_b2,   // bank b on output side
  sample_hold_link_if.device link                  // link to the controller
);
  sample_hold_pkg::array_mode_t mode;
  logic       prev_a;
  logic       prev_b;
  logic       prev_c;
  logic       prev_inh;
  logic       start_prev;
  logic       rise_a;
  logic       step;
  logic       inh_rise;
  logic       inh_fall;
  logic       start_in;
  logic       armed;
  logic       active;
  logic       bank_sel;
  logic       cascade;
  logic [7:0] col;
  logic [7:0] step_size;
  logic [1:0] slot;
  logic [1:0] rotation;
  logic [3:0] inh_cnt;

  function automatic sample_hold_pkg::array_mode_t decode_mode(input logic sa, input logic sb);
    return sample_hold_pkg::array_mode_t'({sa, sb});
  endfunction

  function automatic logic [1:0] add_mod3(input logic [1:0] x, input logic [1:0] y);
    logic [2:0] s;
    s = {1'b0, x} + {1'b0, y};
    return (s > 3'(sample_hold_pkg::SLOT_LAST)) ? 2'(s - 3'h3) : s[1:0];
  endfunction

  assign mode      = decode_mode(link.array_select_a, link.array_select_b);
  // start sampled at phase a rise
  assign rise_a    = link.shift_clock_phase_a & !prev_a;
  // stripe steps on phase a only
  assign step      = (mode == sample_hold_pkg::ARR_STRIPE) ? rise_a
                     : (rise_a | (link.shift_clock_phase_b & !prev_b)
                               | (link.shift_clock_phase_c & !prev_c));
  assign step_size = (mode == sample_hold_pkg::ARR_STRIPE) ? sample_hold_pkg::STRIPE_STEP
                                                         : sample_hold_pkg::SERIAL_STEP;
  assign inh_rise  = link.output_inhibit & !prev_inh;
  assign inh_fall  = !link.output_inhibit & prev_inh;
  assign start_in  = link.direction_select ? link.right_cascade_pulse
                                           : link.left_cascade_pulse;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_a   <= 1'b0;
      prev_b   <= 1'b0;
      prev_c   <= 1'b0;
      prev_inh <= 1'b0;
    end else begin
      prev_a   <= link.shift_clock_phase_a;
      prev_b   <= link.shift_clock_phase_b;
      prev_c   <= link.shift_clock_phase_c;
      prev_inh <= link.output_inhibit;
    end
  end

  // inhibit width, arming, bank swap and line rotation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inh_cnt  <= 4'h0;
      armed    <= 1'b0;
      bank_sel <= 1'b0;
      rotation <= 2'h0;
    end else if (link.panel_reset) begin
      inh_cnt  <= 4'h0;
      armed    <= 1'b0;
      bank_sel <= 1'b0;
      rotation <= 2'h0;
    end else begin
      if (inh_rise) begin
        inh_cnt <= 4'h0;
      end else if (link.output_inhibit && rise_a && inh_cnt != sample_hold_pkg::INH_CNT_MAX) begin
        inh_cnt <= inh_cnt + 4'h1;
      end
      if (inh_fall) begin
        bank_sel <= !bank_sel;
        // a pulse shorter than five clocks does not arm the logic
        if (inh_cnt >= sample_hold_pkg::INH_MIN_CNT) begin
          armed <= 1'b1;
        end
        case (mode)
          sample_hold_pkg::ARR_STRIPE: rotation <= 2'h0;
          sample_hold_pkg::ARR_MOSAIC: rotation <= add_mod3(rotation, 2'h1);
          default:                     rotation <= {1'b0, !rotation[0]};
        endcase
      end
    end
  end

  // switch and output gating, both moved only by panel reset and inhibit edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_bank_switch_a1  <= 1'b0;
      hold_bank_switch_b2  <= 1'b0;
      column_output_enable <= 1'b0;
    end else if (link.panel_reset) begin
      hold_bank_switch_a1  <= 1'b0;
      hold_bank_switch_b2  <= 1'b0;
      column_output_enable <= 1'b0;
    end else if (inh_rise) begin
      column_output_enable <= 1'b0;
      hold_bank_switch_b2  <= 1'b0;
    end else if (inh_fall) begin
      // bank_sel flips on this same edge; the switches follow its new value
      hold_bank_switch_a1  <= !bank_sel;
      hold_bank_switch_b2  <= !bank_sel;
      column_output_enable <= armed | (inh_cnt >= sample_hold_pkg::INH_MIN_CNT);
    end
  end

  // column walk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_prev <= 1'b0;
      active     <= 1'b0;
      col        <= 8'h00;
      slot       <= 2'h0;
      cascade    <= 1'b0;
    end else if (link.panel_reset) begin
      start_prev <= 1'b0;
      active     <= 1'b0;
      col        <= 8'h00;
      slot       <= 2'h0;
      cascade    <= 1'b0;
    end else begin
      if (rise_a) begin
        start_prev <= start_in;
        // cascade lasts one phase a period in every mode
        cascade    <= 1'b0;
      end
      // only the start edge counts, width ignored
      if (rise_a && start_in && !start_prev && armed && !active) begin
        active <= 1'b1;
        col    <= 8'h00;
        slot   <= 2'h0;
      end else if (active && step) begin
        // after last column pass start on
        if (col + step_size > sample_hold_pkg::LAST_COL) begin
          active  <= 1'b0;
          cascade <= 1'b1;
        end else begin
          col  <= col + step_size;
          slot <= add_mod3(slot, 2'h1);
        end
      end
    end
  end

  // at most one group high, mapped by direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      column_sampling_pulse <= '0;
      video_select          <= 2'h0;
    end else begin
      for (int i = 0; i < sample_hold_pkg::COLUMNS; i++) begin
        column_sampling_pulse[link.direction_select ? i : sample_hold_pkg::COLUMNS - 1 - i]
          <= active && (8'(i) >= col) && (8'(i) < col + step_size);
      end
      video_select <= (!active || mode == sample_hold_pkg::ARR_STRIPE) ? 2'h0
                      : add_mod3(slot, rotation) + 2'h1;
    end
  end

  // cascade output pin opposite the input
  assign link.dev_left_o   = cascade;
  assign link.dev_right_o  = cascade;
  assign link.dev_left_oe  = link.direction_select;
  assign link.dev_right_oe = !link.direction_select;
endmodule // column_sample_hold_sequencer

/* sample_hold_link_if.sv */
`timescale 1ns/1ps
interface sample_hold_link_if;
  logic       shift_clock_phase_a;
  logic       shift_clock_phase_b;
  logic       shift_clock_phase_c;
  logic       output_inhibit;
  logic       panel_reset;
  logic       array_select_a;
  logic       array_select_b;
  logic       direction_select;
  logic       dev_right_o;
  logic       dev_right_oe;
  logic       dev_left_o;
  logic       dev_left_oe;
  logic       ctl_right_o;
  logic       ctl_right_oe;
  logic       ctl_left_o;
  logic       ctl_left_oe;
  logic       right_cascade_pulse;
  logic       left_cascade_pulse;

  // wire level resolved from enables; undriven reads low
  assign right_cascade_pulse = dev_right_oe ? dev_right_o : (ctl_right_oe & ctl_right_o);
  assign left_cascade_pulse  = dev_left_oe ? dev_left_o : (ctl_left_oe & ctl_left_o);

  modport device (
    input  shift_clock_phase_a, shift_clock_phase_b, shift_clock_phase_c,
    input  output_inhibit, panel_reset, array_select_a, array_select_b,
    input  direction_select, right_cascade_pulse, left_cascade_pulse,
    output dev_right_o, dev_right_oe, dev_left_o, dev_left_oe
  );
  modport controller (
    output shift_clock_phase_a, shift_clock_phase_b, shift_clock_phase_c,
    output output_inhibit, panel_reset, array_select_a, array_select_b,
    output direction_select, ctl_right_o, ctl_right_oe, ctl_left_o, ctl_left_oe,
    input  right_cascade_pulse, left_cascade_pulse
  );
endinterface

/* sample_hold_monitor.sv */
`timescale 1ns/1ps
module sample_hold_monitor (
  input wire logic         hclk,                  // clock
  input wire logic         hresetn,               // reset, active low
  input wire logic         shift_clock_phase_a,   // phase a
  input wire logic         shift_clock_phase_b,   // phase b
  input wire logic         shift_clock_phase_c,   // phase c
  input wire logic         output_inhibit,        // inhibit
  input wire logic         panel_reset,           // device reset
  input wire logic         array_select_a,        // mode pin a
  input wire logic         array_select_b,        // mode pin b
  input wire logic         direction_select,      // walk direction
  input wire logic         dev_right_o,           // right pin drive
  input wire logic         dev_right_oe,          // right pin enable
  input wire logic         dev_left_o,            // left pin drive
  input wire logic         dev_left_oe,           // left pin enable
  input wire logic [239:0] column_sampling_pulse, // sampling group
  input wire logic [1:0]   video_select,          // video route
  input wire logic         column_output_enable,  // outputs driven
  input wire logic         hold_bank_switch_a1    // bank state
);
  logic         pa_d, pb_d, pc_d, casc_d, seen_fall;
  logic [2:0]   inh_sr, pr_sr;
  logic [239:0] csp_d;
  logic [8:0]   steps;
  wire stripe  = !(array_select_a | array_select_b);
  wire rise_a  = shift_clock_phase_a & !pa_d;
  wire rise_s  = rise_a | (shift_clock_phase_b & !pb_d) | (shift_clock_phase_c & !pc_d);
  wire rise_ok = stripe ? rise_a : rise_s;
  // edges up to three samples back still excuse a bank move
  wire inh_rec = (|{output_inhibit, inh_sr}) && !(&{output_inhibit, inh_sr});
  wire pr_rec  = |{panel_reset, pr_sr};
  wire casc    = (dev_left_oe & dev_left_o) | (dev_right_oe & dev_right_o);
  wire step    = (|column_sampling_pulse) && (column_sampling_pulse != csp_d);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {pa_d, pb_d, pc_d, casc_d} <= 4'h0;
      inh_sr <= 3'h0;
      pr_sr  <= 3'h0;
      csp_d  <= '0;
    end else begin
      {pa_d, pb_d, pc_d, casc_d} <= {shift_clock_phase_a, shift_clock_phase_b,
                                     shift_clock_phase_c, casc};
      inh_sr <= {inh_sr[1:0], output_inhibit};
      pr_sr  <= {pr_sr[1:0], panel_reset};
      csp_d  <= column_sampling_pulse;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      seen_fall <= 1'h0;
    else if (panel_reset)
      seen_fall <= 1'h0;
    else if (inh_sr[0] && !output_inhibit)
      seen_fall <= 1'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      steps <= 9'h0;
    else if (pr_rec || (casc && !casc_d))
      steps <= 9'h0;
    else if (step)
      steps <= steps + 9'h1;
  end

  default clocking mon_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_bank_still:
    assert property ($changed(hold_bank_switch_a1) |-> inh_rec || pr_rec)
    else $error("bank switch moved without inhibit edge");
  chk_bank_swap:
    assert property ($fell(output_inhibit) |-> ##[1:3] $changed(hold_bank_switch_a1))
    else $error("banks not swapped after inhibit fall");
  chk_float_high:
    assert property (output_inhibit [*3] |-> !column_output_enable)
    else $error("outputs driven while inhibit high");
  chk_no_early:
    assert property (!seen_fall && !pr_rec |-> column_sampling_pulse == '0)
    else $error("sampling before first inhibit pulse");
  chk_group_size:
    assert property (|column_sampling_pulse |->
      $countones(column_sampling_pulse) == (stripe ? 3 : 1))
    else $error("wrong number of columns sampling");
  chk_video_route:
    assert property (|column_sampling_pulse |->
      (stripe ? video_select == 2'h0 : video_select != 2'h0))
    else $error("video route does not match mode");
  chk_phase_cause:
    assert property (step |-> $past(rise_ok, 1) || $past(rise_ok, 2) || $past(rise_ok, 3))
    else $error("sampling step without shift clock rise");
  chk_line_length:
    assert property (casc && !casc_d |-> steps == (stripe ? 9'h50 : 9'hF0))
    else $error("cascade out after wrong step count");
  chk_first_group:
    assert property (step && csp_d == '0 |->
      (direction_select ? column_sampling_pulse[0] : column_sampling_pulse[239]))
    else $error("line started at wrong end");
  chk_far_pin:
    assert property (!pr_rec && direction_select == $past(direction_select)
      && direction_select == $past(direction_select, 2)
      |-> dev_left_oe == direction_select && dev_right_oe != direction_select)
    else $error("device drives wrong cascade pin");
endmodule // sample_hold_monitor

/* sample_hold_pkg.sv */
package sample_hold_pkg;
  // column geometry
  localparam int          COLUMNS     = 240;
  localparam logic [7:0]  LAST_COL    = 8'hEF;
  localparam logic [7:0]  STRIPE_STEP = 8'h03;
  localparam logic [7:0]  SERIAL_STEP = 8'h01;
  localparam logic [1:0]  SLOT_LAST   = 2'h2;

  typedef enum logic [1:0] {
    ARR_STRIPE       = 2'b00,
    ARR_DELTA_SINGLE = 2'b01,
    ARR_MOSAIC       = 2'b10,
    ARR_DELTA_DOUBLE = 2'b11
  } array_mode_t;

  // inhibit width in shift clock periods
  localparam int          INH_MIN_CLOCKS = 5;
  localparam logic [3:0]  INH_MIN_CNT    = 4'(INH_MIN_CLOCKS);
  localparam logic [3:0]  INH_CNT_MAX    = 4'hF;

  // timing against hclk
  localparam int HCLK_MHZ         = 50;
  localparam int HCLK_NS          = 20;
  localparam int SHIFT_SINGLE_MHZ = 15;
  localparam int SHIFT_TRIPLE_MHZ = 8;
  localparam int RESET_PW_NS      = 66;
  localparam int RESET_INH_NS     = 81;
  localparam logic [2:0] SINGLE_PERIOD = 3'(HCLK_MHZ / SHIFT_SINGLE_MHZ);
  localparam logic [2:0] TRIPLE_PERIOD = 3'(HCLK_MHZ / SHIFT_TRIPLE_MHZ);
  localparam logic [2:0] PHASE_WIDTH   = 3'(HCLK_MHZ / SHIFT_TRIPLE_MHZ / 3);
  localparam logic [3:0] RESET_CYCLES  = 4'((RESET_PW_NS + HCLK_NS - 1) / HCLK_NS);
  localparam logic [3:0] RESET_INH_CYC = 4'((RESET_INH_NS + HCLK_NS - 1) / HCLK_NS);

  // controller registers over AHB-Lite
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_LINES  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_MODE_L = 1;
  localparam int CTRL_DIR    = 3;
  localparam int STAT_BUSY   = 16;
  localparam int STAT_VCOM   = 17;
  localparam logic [8:0] LINES_RESET = 9'h0F0;
endpackage

/* testbench.sv */
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
module testbench;
  logic         hclk, hresetn, hsel, hwrite, vcom_flip, hresp;
  logic [31:0]  haddr, hwdata, hrdata, lfsr, ctrl;
  logic [1:0]   htrans, video_select, slot;
  logic [2:0]   hsize;
  wire          hready;
  logic [239:0] column_sampling_pulse, csp_d;
  logic         column_output_enable, hold_bank_switch_a1, hold_bank_switch_b2;
  logic         casc_d, inh_d, fall_bank, vcom_d;
  int           err_count, samples_checked, steps, lines_seen, since_fall, target, waited;

  sample_hold_link_if link ();
  timing_controller timing_controller_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .vcom_flip, .link(link));
  column_sample_hold_sequencer column_sample_hold_sequencer_inst (.hclk, .hresetn,
    .column_sampling_pulse, .video_select, .column_output_enable, .hold_bank_switch_a1,
    .hold_bank_switch_b2, .link(link));
  sample_hold_monitor sample_hold_monitor_inst (.hclk, .hresetn,
    .shift_clock_phase_a(link.shift_clock_phase_a), .shift_clock_phase_b(link.shift_clock_phase_b),
    .shift_clock_phase_c(link.shift_clock_phase_c), .output_inhibit(link.output_inhibit),
    .panel_reset(link.panel_reset), .array_select_a(link.array_select_a),
    .array_select_b(link.array_select_b), .direction_select(link.direction_select),
    .dev_right_o(link.dev_right_o), .dev_right_oe(link.dev_right_oe),
    .dev_left_o(link.dev_left_o), .dev_left_oe(link.dev_left_oe),
    .column_sampling_pulse, .video_select, .column_output_enable, .hold_bank_switch_a1);

  wire casc = (link.dev_left_oe & link.dev_left_o) | (link.dev_right_oe & link.dev_right_o);
  wire serial = link.array_select_a | link.array_select_b;

  always #(sample_hold_pkg::HCLK_NS / 2) hclk = ~hclk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int exp_steps(input logic ser);
    return ser ? sample_hold_pkg::COLUMNS : sample_hold_pkg::COLUMNS / 3;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic bus_cycle(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                           output logic [31:0] rdata);
    @(posedge hclk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h0, addr};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge hclk); while (hready !== 1'h1);
    rdata = hrdata;
  endtask
  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    bus_cycle(1'h1, addr, data, unused);
  endtask
  task automatic reg_check(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    bus_cycle(1'h0, addr, 32'h0, got);
    `CHECK(got, exp)
  endtask

  // line walk observer: step count, start column, serial input order, bank swap
  always @(posedge hclk) begin
    csp_d  <= column_sampling_pulse;
    casc_d <= casc;
    inh_d  <= link.output_inhibit;
    vcom_d <= vcom_flip;
    if (hresetn && vcom_flip !== vcom_d)
      `CHECK(link.output_inhibit, 1'h1)
    if (hresetn && link.panel_reset)
      steps = 0;
    if (hresetn && |column_sampling_pulse && column_sampling_pulse !== csp_d) begin
      steps++;
      if (csp_d == '0)
        `CHECK(link.direction_select ? column_sampling_pulse[0] : column_sampling_pulse[239], 1'h1)
      if (serial && csp_d != '0)
        `CHECK(video_select, (slot == 2'h3) ? 2'h1 : slot + 2'h1)
      slot = video_select;
    end
    if (hresetn && casc && !casc_d) begin
      `CHECK(steps, exp_steps(serial))
      steps = 0;
      lines_seen++;
    end
    if (inh_d && !link.output_inhibit) begin
      fall_bank = hold_bank_switch_a1;
      since_fall = 0;
    end else if (since_fall >= 0)
      since_fall++;
    if (since_fall == 4) begin
      `CHECK(column_output_enable, 1'h1)
      `CHECK(hold_bank_switch_a1, ~fall_bank)
      since_fall = -1;
    end
  end

  initial begin
    hclk = 1'h0; hresetn = 1'h0; hsel = 1'h0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'h0;
    hsize = 3'h2; hwdata = 32'h0; lfsr = 32'h28CB; slot = 2'h0; since_fall = -1;
    err_count = 0; samples_checked = 0; steps = 0; lines_seen = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    `CHECK(column_sampling_pulse, 240'h0)
    `CHECK(column_output_enable, 1'h0)
    `CHECK({hold_bank_switch_a1, hold_bank_switch_b2}, 2'h0)
    reg_check(sample_hold_pkg::REG_CTRL, 32'h8);
    reg_check(sample_hold_pkg::REG_LINES, 32'hF0);
    reg_check(sample_hold_pkg::REG_STATUS, 32'h0);
    lfsr = lfsr_next(lfsr);
    reg_write(8'h0C, lfsr);
    reg_check(8'h0C, 32'h0);
    reg_write(sample_hold_pkg::REG_LINES, 32'h2);
    $display("reset and register test done");
    // every array mode, random walk direction, three lines so a frame reset falls inside
    for (int m = 0; m < 4; m++) begin
      lfsr = lfsr_next(lfsr);
      ctrl = {28'h0, lfsr[0], 2'(m), 1'h1};
      reg_write(sample_hold_pkg::REG_CTRL, ctrl);
      reg_check(sample_hold_pkg::REG_CTRL, ctrl);
      target = lines_seen + 3;
      waited = 0;
      while (lines_seen < target && waited < 8000) begin
        @(posedge hclk);
        waited++;
      end
      `CHECK({link.array_select_a, link.array_select_b}, 2'(m))
      `CHECK(link.direction_select, lfsr[0])
      `CHECK(lines_seen >= target, 1'h1)
      reg_write(sample_hold_pkg::REG_CTRL, {ctrl[31:1], 1'h0});
      waited = 0;
      while ((column_sampling_pulse !== '0 || link.output_inhibit !== 1'h0) && waited < 2000) begin
        @(posedge hclk);
        waited++;
      end
      `CHECK(waited < 2000, 1'h1)
      $display("mode %0d test done, lines %0d", m, lines_seen);
    end
    test_done();
  end

  initial begin
    repeat (60000) @(posedge hclk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule // testbench

/* timing_controller.sv */
`timescale 1ns/1ps
module timing_controller (
  input  wire logic        hclk,        // system clock
  input  wire logic        hresetn,     // async reset, active low
  input  wire logic        hsel,        // slave select
  input  wire logic [31:0] haddr,       // byte address
  input  wire logic [1:0]  htrans,      // transfer type
  input  wire logic        hwrite,      // write strobe
  input  wire logic [2:0]  hsize,       // transfer size
  input  wire logic [31:0] hwdata,      // write data
  input  wire logic        hready,      // bus ready
  output logic      [31:0] hrdata,      // read data
  output logic             hreadyout,   // slave ready
  output logic             hresp,       // response
  output logic             vcom_flip,   // panel common polarity
  sample_hold_link_if.controller link   // link to the driver
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RESET = 3'b001,
    ST_GAP   = 3'b010,
    ST_INH   = 3'b011,
    ST_START = 3'b100,
    ST_SCAN  = 3'b101
  } ctl_state_t;

  ctl_state_t  state;
  logic        enable;
  logic [1:0]  mode;
  logic        dir;
  logic [8:0]  lines;
  logic [15:0] line_cnt;
  logic [3:0]  wait_cnt;
  logic [2:0]  ph_cnt;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        start;
  logic        stripe;
  logic        a_tick;
  logic        far_pin;
  logic        addr_ok;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];
  assign stripe    = (mode == sample_hold_pkg::ARR_STRIPE);
  assign a_tick    = (ph_cnt == 3'h0);
  assign far_pin   = dir ? link.left_cascade_pulse : link.right_cascade_pulse;

  // bus slave: write lands in data phase, read data registered at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      enable  <= 1'b0;
      mode    <= 2'h0;
      dir     <= 1'b1;
      lines   <= sample_hold_pkg::LINES_RESET;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr[7:0];
      if (wr_pend && wr_addr == sample_hold_pkg::REG_CTRL) begin
        enable <= hwdata[sample_hold_pkg::CTRL_ENABLE];
        mode   <= hwdata[sample_hold_pkg::CTRL_MODE_L +: 2];
        dir    <= hwdata[sample_hold_pkg::CTRL_DIR];
      end
      if (wr_pend && wr_addr == sample_hold_pkg::REG_LINES) begin
        lines <= hwdata[8:0];
      end
      if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          sample_hold_pkg::REG_CTRL:   hrdata <= {28'h0000000, dir, mode, enable};
          sample_hold_pkg::REG_LINES:  hrdata <= {23'h000000, lines};
          sample_hold_pkg::REG_STATUS: hrdata <= {14'h0000, vcom_flip,
                                                  state != ST_IDLE, line_cnt};
          default:                     hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_cnt                   <= 3'h0;
      link.shift_clock_phase_a <= 1'b0;
      link.shift_clock_phase_b <= 1'b0;
      link.shift_clock_phase_c <= 1'b0;
    end else begin
      if (!enable) begin
        ph_cnt <= 3'h0;
      end else if (ph_cnt == (stripe ? sample_hold_pkg::SINGLE_PERIOD
                                     : sample_hold_pkg::TRIPLE_PERIOD) - 3'h1) begin
        ph_cnt <= 3'h0;
      end else begin
        ph_cnt <= ph_cnt + 3'h1;
      end
      link.shift_clock_phase_a <= enable & (ph_cnt < sample_hold_pkg::PHASE_WIDTH);
      link.shift_clock_phase_b <= enable & !stripe & (ph_cnt >= sample_hold_pkg::PHASE_WIDTH)
                                  & (ph_cnt < 3'(2 * sample_hold_pkg::PHASE_WIDTH));
      link.shift_clock_phase_c <= enable & !stripe
                                  & (ph_cnt >= 3'(2 * sample_hold_pkg::PHASE_WIDTH));
    end
  end

  // line and frame sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state               <= ST_IDLE;
      wait_cnt            <= 4'h0;
      line_cnt            <= 16'h0000;
      start               <= 1'b0;
      vcom_flip           <= 1'b0;
      link.panel_reset    <= 1'b0;
      link.output_inhibit <= 1'b0;
    end else if (!enable) begin
      state               <= ST_IDLE;
      start               <= 1'b0;
      link.panel_reset    <= 1'b0;
      link.output_inhibit <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          state            <= ST_RESET;
          wait_cnt         <= 4'h0;
          link.panel_reset <= 1'b1;
        end
        ST_RESET: begin
          wait_cnt <= wait_cnt + 4'h1;
          if (wait_cnt == sample_hold_pkg::RESET_CYCLES - 4'h1) begin
            link.panel_reset <= 1'b0;
            wait_cnt         <= 4'h0;
            state            <= ST_GAP;
          end
        end
        ST_GAP: begin
          wait_cnt <= wait_cnt + 4'h1;
          if (wait_cnt == sample_hold_pkg::RESET_INH_CYC - 4'h1) begin
            wait_cnt            <= 4'h0;
            line_cnt            <= 16'h0000;
            link.output_inhibit <= 1'b1;
            state               <= ST_INH;
          end
        end
        ST_INH: begin
          if (a_tick) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == 4'h0) begin
              vcom_flip <= !vcom_flip;
            end
            // drop on the sixth tick, so five whole periods lie inside the pulse
            if (wait_cnt == sample_hold_pkg::INH_MIN_CNT) begin
              link.output_inhibit <= 1'b0;
              state               <= ST_START;
            end
          end
        end
        ST_START: begin
          if (a_tick) begin
            start <= !start;
            if (start) begin
              state <= ST_SCAN;
            end
          end
        end
        ST_SCAN: begin
          if (far_pin) begin
            wait_cnt <= 4'h0;
            line_cnt <= line_cnt + 16'h0001;
            if (line_cnt + 16'h0001 >= {7'h00, lines}) begin
              link.panel_reset <= 1'b1;
              state            <= ST_RESET;
            end else begin
              link.output_inhibit <= 1'b1;
              state               <= ST_INH;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // start pulse enters on the near pin, driver returns it on the far pin
  assign link.array_select_a   = mode[1];
  assign link.array_select_b   = mode[0];
  assign link.direction_select = dir;
  assign link.ctl_right_o      = start;
  assign link.ctl_left_o       = start;
  assign link.ctl_right_oe     = dir;
  assign link.ctl_left_oe      = !dir;
endmodule // timing_controller
